// ===== design/infoframe_status_cfg.svh
// Register offsets, field positions and reset values of the packet status bank
`ifndef INFOFRAME_STATUS_CFG_SVH
`define INFOFRAME_STATUS_CFG_SVH

// Register word indices; byte address is four times the index
`define OFS_PIXEL_REPETITION      8'h85
`define OFS_TOP_BAR_END_LOW       8'h86
`define OFS_PACKET_CHANGE_FLAGS_A 8'h87
`define OFS_TOP_BAR_END_HIGH      8'h88
`define OFS_BOTTOM_BAR_START_LOW  8'h89
`define OFS_BOTTOM_BAR_START_HIGH 8'h8a
`define OFS_LEFT_BAR_END_LOW      8'h8b
`define OFS_LEFT_BAR_END_HIGH     8'h8c
`define OFS_RIGHT_BAR_START_LOW   8'h8d
`define OFS_RIGHT_BAR_START_HIGH  8'h8e
`define OFS_PACKET_CHANGE_FLAGS_B 8'h8f
`define OFS_AUDIO_PACKET_VERSION  8'h90
`define OFS_AUDIO_CODING_KIND     8'h91
`define OFS_IRQ_STATUS            8'ha0
`define OFS_IRQ_CLEAR             8'ha1
`define OFS_IRQ_ENABLE            8'ha2

// Field positions
`define PIXEL_REP_MSB             3
`define CODING_KIND_LSB           4
`define FLAG_AVI                  0
`define FLAG_AUDIO                1
`define FLAG_SPD                  2
`define FLAG_MPEG                 3
`define FLAG_ACP                  4
`define FLAG_ISRC1                5
`define FLAG_ISRC2                6
`define NUM_PACKET_KINDS          7

// Reset values
`define RST_BYTE                  8'h00
`define RST_WORD                  16'h0000
`define RST_FLAGS                 7'h00

`endif

// ===== design/infoframe_status_pkg.sv
// Types shared by the packet status bank
package infoframe_status_pkg;

  // Captured packet fields as held by the bank
  typedef struct packed {
    logic [3:0]  pixel_repetition_factor;
    logic [15:0] top_bar_end;
    logic [15:0] bottom_bar_start;
    logic [15:0] left_bar_end;
    logic [15:0] right_bar_start;
    logic [7:0]  audio_packet_version;
    logic [3:0]  audio_coding_kind;
  } fields_t;

endpackage

// ===== design/change_flag_if.sv
// Interface between the bank and its sticky change flag store
`timescale 1ns/1ps
interface change_flag_if #(parameter int N = 7);
  logic [N-1:0] set_pulse;
  logic         clear_all;
  logic [N-1:0] flags;

  modport bank  (output set_pulse, output clear_all, input flags);
  modport store (input set_pulse, input clear_all, output flags);
endinterface

// ===== design/change_flag_store.sv
// Sticky packet change flags, set per kind, cleared all at once
`timescale 1ns/1ps
module change_flag_store #(
  parameter int N = 7
) (
  // Clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Flag traffic
  change_flag_if.store cf
);

  typedef struct packed {
    logic [N-1:0] flags;
  } store_state_t;

  store_state_t state_ff;
  store_state_t nxt_state;

  // One generate block per kind; a new change beats a clear in the same cycle
  genvar g;
  for (g = 0; g < N; g++) begin : g_flag
    always_comb begin
      nxt_state.flags[g] = state_ff.flags[g];
      if (cf.clear_all) begin
        nxt_state.flags[g] = 1'b0;          // R7
      end
      if (cf.set_pulse[g]) begin
        nxt_state.flags[g] = 1'b1;          // R6
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign cf.flags = state_ff.flags;

endmodule // change_flag_store

// ===== design/infoframe_status_regs.sv
// Read-only bank of captured video and audio packet fields behind APB
//
// Summary of operation
// R1: Four-bit pixel repetition, values above nine reserved
// R2: Top bar end line, 16 bits, zero none
// R3: Bottom bar start line, 16-bit byte pair
// R4: Left bar last pixel, 16 bits, zero none
// R5: Right bar first pixel, 16-bit byte pair
// R6: Flag set when a packet kind changes
// R7: Reading any flag copy clears all flags
// R8: Every flag copy shows identical contents
// R9: Seven flags, one per packet kind
// R10: Flags in listed order from bit zero
// R11: Audio coding kind in upper nibble
// R12: Host writes to bank are ignored
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "infoframe_status_cfg.svh"
module infoframe_status_regs #(
  parameter int NKINDS = `NUM_PACKET_KINDS
) (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Packet receiver capture port
  input  wire logic                          cap_valid,
  input  wire infoframe_status_pkg::fields_t cap_fields,
  input  wire logic [NKINDS-1:0]             packet_changed,
  // Interrupt
  output logic                               irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    infoframe_status_pkg::fields_t fields;
    logic [NKINDS-1:0]             irq_status;
    logic [NKINDS-1:0]             irq_enable;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
    logic                          irq;
  } bank_state_t;

  bank_state_t state_ff;
  bank_state_t nxt_state;

  change_flag_if #(.N(NKINDS)) cf ();

  change_flag_store #(
    .N (NKINDS)
  ) u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .cf      (cf)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic [7:0]  word_idx;
  logic        in_range;
  logic        acc_done;
  logic        wr_done;
  logic        is_flag_copy;

  // Index is address over four; upper bits must be zero to hit the bank
  assign word_idx = paddr[9:2];
  assign in_range = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  // Answer is one cycle after setup: pready is high in the first access cycle
  assign acc_done = psel && penable && state_ff.pready;
  assign wr_done  = acc_done && pwrite;
  assign is_flag_copy = (word_idx == `OFS_PACKET_CHANGE_FLAGS_A) ||
                        (word_idx == `OFS_PACKET_CHANGE_FLAGS_B);   // R8

  // Flag store traffic. The clear lands on the edge that captures the read
  // word, so a change seen on that edge survives (set wins) and no change
  // can slip in between the captured value and the clear.
  assign cf.set_pulse = packet_changed;                              // R6
  assign cf.clear_all = psel && !penable && !pwrite && in_range &&
                        is_flag_copy;                                // R7

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  function automatic logic [31:0] read_word(input logic [7:0] idx,
                                             input bank_state_t s,
                                             input logic [NKINDS-1:0] fl,
                                             output logic hit);
    logic [31:0] d;
    d   = 32'h0000_0000;
    hit = 1'b1;
    case (idx)
      `OFS_PIXEL_REPETITION: begin
        d[`PIXEL_REP_MSB:0] = s.fields.pixel_repetition_factor;  // R1
      end
      `OFS_TOP_BAR_END_LOW:       d[7:0] = s.fields.top_bar_end[7:0];        // R2
      `OFS_TOP_BAR_END_HIGH:      d[7:0] = s.fields.top_bar_end[15:8];       // R2
      `OFS_BOTTOM_BAR_START_LOW:  d[7:0] = s.fields.bottom_bar_start[7:0];   // R3
      `OFS_BOTTOM_BAR_START_HIGH: d[7:0] = s.fields.bottom_bar_start[15:8];  // R3
      `OFS_LEFT_BAR_END_LOW:      d[7:0] = s.fields.left_bar_end[7:0];       // R4
      `OFS_LEFT_BAR_END_HIGH:     d[7:0] = s.fields.left_bar_end[15:8];      // R4
      `OFS_RIGHT_BAR_START_LOW:   d[7:0] = s.fields.right_bar_start[7:0];    // R5
      `OFS_RIGHT_BAR_START_HIGH:  d[7:0] = s.fields.right_bar_start[15:8];   // R5
      `OFS_PACKET_CHANGE_FLAGS_A,
      `OFS_PACKET_CHANGE_FLAGS_B: begin
        d[NKINDS-1:0] = fl;                                      // R8 R9 R10
      end
      `OFS_AUDIO_PACKET_VERSION:  d[7:0] = s.fields.audio_packet_version;
      `OFS_AUDIO_CODING_KIND: begin
        d[7:`CODING_KIND_LSB] = s.fields.audio_coding_kind;      // R11
      end
      `OFS_IRQ_STATUS:            d[NKINDS-1:0] = s.irq_status;
      `OFS_IRQ_ENABLE:            d[NKINDS-1:0] = s.irq_enable;
      `OFS_IRQ_CLEAR:             d = 32'h0000_0000;             // Write-only
      default: begin
        hit = 1'b0;
      end
    endcase
    return d;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [31:0] rd_word;
  logic        rd_hit;

  always_comb begin
    rd_word = read_word(word_idx, state_ff, cf.flags, rd_hit);
  end

  // Fields, interrupt bits and bus answer
  always_comb begin
    nxt_state = state_ff;
    // Receiver capture owns the field store; the host has no write path
    if (cap_valid) begin
      nxt_state.fields = cap_fields;                             // R12
    end
    // Interrupt clear by write-one, but a new event wins over the clear
    if (wr_done && in_range && word_idx == `OFS_IRQ_CLEAR && pstrb[0]) begin
      nxt_state.irq_status = state_ff.irq_status & ~pwdata[NKINDS-1:0];
    end
    nxt_state.irq_status = nxt_state.irq_status | packet_changed;
    if (wr_done && in_range && word_idx == `OFS_IRQ_ENABLE && pstrb[0]) begin
      nxt_state.irq_enable = pwdata[NKINDS-1:0];
    end
    nxt_state.irq = |(nxt_state.irq_status & nxt_state.irq_enable);
    // Zero-wait access: ready raised in the first access cycle
    nxt_state.pready  = psel && !penable;
    nxt_state.pslverr = 1'b0;
    nxt_state.prdata  = 32'h0000_0000;
    if (psel && !penable) begin
      if (!pwrite) begin
        nxt_state.prdata  = in_range ? rd_word : 32'h0000_0000;
        nxt_state.pslverr = !(in_range && rd_hit);
      end else begin
        // Writes to the read-only bank are dropped without error
        nxt_state.pslverr = !(in_range && rd_hit);               // R12
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prdata  = state_ff.prdata;
  assign pready  = state_ff.pready;
  assign pslverr = state_ff.pslverr;
  assign irq     = state_ff.irq;

endmodule // infoframe_status_regs

// ===== testbench/infoframe_status_regs_chk.sv
// Port checker of the packet status bank
`timescale 1ns/1ps
module infoframe_status_regs_chk #(parameter int NKINDS = 7) (
  // Clock, reset and bus
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Events and interrupt
  input wire logic [NKINDS-1:0] packet_changed,
  input wire logic              irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [NKINDS-1:0] flags_ff;
  logic              done;
  logic              fl_rd;
  logic              fl_set;
  // -----------------------------------------------------------
  // Shadow flags: cleared when the read word is captured in setup,
  // and a pulse on that same edge must survive
  // -----------------------------------------------------------
  assign done   = psel && penable && pready;
  assign fl_rd  = done && !pwrite && (paddr == 12'h21c || paddr == 12'h23c);
  assign fl_set = psel && !penable && !pwrite && (paddr == 12'h21c || paddr == 12'h23c);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) flags_ff <= '0;
    else flags_ff <= (fl_set ? '0 : flags_ff) | packet_changed;
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_err; psel && !penable && paddr == 12'h000 |=> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_wr;
    psel && !penable && pwrite && paddr[9:2] inside {[8'h85:8'h91]} && paddr[11:10] == 2'h0
      && paddr[1:0] == 2'h0 |=> pready && !pslverr;
  endproperty
  a_wr: assert property (p_wr) else $error("write refused");
  property p_pix; done && !pwrite && paddr == 12'h214 |-> prdata[31:4] == 28'h0; endproperty
  a_pix: assert property (p_pix) else $error("repeat width");
  property p_kind;
    done && !pwrite && paddr == 12'h244 |-> prdata[31:8] == 24'h0 && prdata[3:0] == 4'h0;
  endproperty
  a_kind: assert property (p_kind) else $error("coding nibble");
  property p_byte; done && !pwrite && paddr inside {[12'h218:12'h240]} |-> prdata[31:8] == 24'h0;
  endproperty
  a_byte: assert property (p_byte) else $error("byte width");
  property p_flags; fl_rd |-> prdata == {25'h0, $past(flags_ff)}; endproperty
  a_flags: assert property (p_flags) else $error("flag value");
  c_flags: cover property (fl_rd && prdata != 32'h0);
  c_irq: cover property ($rose(irq));
  c_err: cover property (pready && pslverr);
endmodule // infoframe_status_regs_chk

bind infoframe_status_regs infoframe_status_regs_chk #(.NKINDS(NKINDS)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .packet_changed(packet_changed), .irq(irq));

// ===== testbench/test_infoframe_status_regs.sv
// Self-checking bench of the packet status bank
`timescale 1ns/1ps
module test_infoframe_status_regs;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, cap_valid, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [95:0] rv;
  logic [6:0] packet_changed, mf, ms;
  infoframe_status_pkg::fields_t cap_fields, f;
  int error_cnt, tests_run, seed;
  logic [7:0] idx [13] = '{8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
                           8'h8e, 8'h8f, 8'h90, 8'h91};
  infoframe_status_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_valid(cap_valid),
    .cap_fields(cap_fields), .packet_changed(packet_changed), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Expected word: byte lanes of the bank in index order
  function automatic logic [31:0] ev(input logic [7:0] i);
    logic [103:0] b;
    b = {f.audio_coding_kind, 4'h0, f.audio_packet_version, 1'b0, mf, f.right_bar_start,
         f.left_bar_end, f.bottom_bar_start, f.top_bar_end[15:8], 1'b0, mf,
         f.top_bar_end[7:0], 4'h0, f.pixel_repetition_factor};
    return {24'h0, b[8*(int'(i)-133) +: 8]};
  endfunction
  // Read and compare; a flag read empties every copy in the model
  task automatic rdchk(input logic [7:0] i);
    apb(1'b0, i, 32'h0);
    chk(rd, ev(i));
    chk({31'h0, er}, 32'h0);
    if (i == 8'h87 || i == 8'h8f) mf = '0;
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge pclk);
    packet_changed <= m;
    @(posedge pclk);
    packet_changed <= '0;
    mf |= m;
    ms |= m;
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, v});
  endtask
  initial begin
    seed = 32'h3404117c;
    {psel, penable, pwrite, cap_valid, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    packet_changed = '0;
    cap_fields = '0;
    {f, mf, ms} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then random captures; writes must change nothing
    for (int it = 0; it < 4; it++) begin
      if (it > 0) begin
        rv = {$random(seed), $random(seed), $random(seed)};
        f = rv[79:0];
        f.pixel_repetition_factor = (it == 1) ? 4'h9 : 4'({$random(seed)} % 10);
        f.audio_coding_kind = (it == 1) ? 4'h8 : 4'({$random(seed)} % 9);
        @(posedge pclk);
        cap_fields <= f;
        cap_valid <= 1'b1;
        @(posedge pclk);
        cap_valid <= 1'b0;
      end
      for (int j = 0; j < 13; j++) apb(1'b1, idx[j], $random(seed));
      for (int j = 0; j < 13; j++) rdchk(idx[j]);
    end
    // Each kind alone, then a mix read through copy B, after which copy A reads empty
    for (int k = 0; k < 7; k++) begin
      pulse(7'h1 << k);
      rdchk(8'h87);
    end
    pulse(7'($random(seed)) | 7'h1);
    rdchk(8'h8f);
    rdchk(8'h87);
    // A change landing on the edge that captures a flag read is kept
    fork
      apb(1'b0, 8'h87, 32'h0);
      pulse(7'h10);
    join
    chk(rd, 32'h0);
    rdchk(8'h8f);
    // Interrupt: enable, clear, mask
    apb(1'b1, 8'ha2, 32'h7f);
    apb(1'b0, 8'ha0, 32'h0);
    chk(rd, {25'h0, ms});
    irq_is(1'b1);
    apb(1'b1, 8'ha1, 32'h7f);
    ms = '0;
    irq_is(1'b0);
    apb(1'b1, 8'ha2, 32'h1);
    pulse(7'h2);
    irq_is(1'b0);
    pulse(7'h1);
    irq_is(1'b1);
    apb(1'b1, 8'ha1, 32'h1);
    irq_is(1'b0);
    apb(1'b0, 8'ha0, 32'h0);
    chk(rd, 32'h2);
    // Unmapped place is refused
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    stop_test();
  end
endmodule // test_infoframe_status_regs
